// [hdl/rtc_spi_device.sv]
// clock-chip serial slave: command decode, RAM, control registers,
// watchdog, power-down and delayed alarm
// assumes link pins are asynchronous and host half periods of 8+ clocks
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/10ps
module rtc_spi_device #(
    parameter int ALARM_DELAY = rtc_spi_pkg::ALARM_DELAY_CYCLES,
    parameter int WDOG_TIMEOUT = rtc_spi_pkg::WDOG_TIMEOUT_CYCLES,
    parameter bit DELAYED_ALARM = 1'b1
) (
    input wire logic clk,
    input wire logic rst,
    rtc_spi_if.dev link,
    input wire logic systemSupplySense,
    input wire logic powerFailEvent,
    input wire logic alarmEvent,
    input wire logic periodicEvent,
    output logic hostResetN,
    output logic powerSwitchEnable,
    output logic clkOutEnable,
    output logic irqActive
);
    logic [1:0] sckSync;
    logic [1:0] ceSync;
    logic [1:0] mosiSync;
    logic [1:0] supplySync;
    logic sckPrev;
    logic cePrev;
    logic supplyPrev;
    logic idleLevel_reg;
    logic [2:0] bitCnt_reg;
    logic gotCmd_reg;
    logic isWrite_reg;
    logic [5:0] addr_reg;
    logic [7:0] shiftIn_reg;
    logic [7:0] shiftOut_reg;
    logic misoOe_reg;
    logic misoOut_reg;
    logic [7:0] status_reg;
    logic [7:0] status_next;
    logic [7:0] intCtl_reg;
    logic [7:0] ram [32];
    logic [7:0] clkRegs [32];
    logic [31:0] wdCnt_reg;
    logic [7:0] rstPulse_reg;
    logic [31:0] alarmCnt_reg;
    logic alarmPending_reg;
    logic hostResetN_reg;
    logic pse_reg;
    logic clkOut_reg;

    logic ceNow;
    logic sckNow;
    logic ceRise;
    logic sckEdge;
    logic strobe;
    logic shiftEdge;
    logic portOff;
    logic byteDone;
    logic [7:0] inByte;
    logic [5:0] cmdAddr;
    logic [5:0] nextAddr;
    logic [5:0] rdAddr;
    logic [7:0] rdData;
    logic loadOut;
    logic statusRead;
    logic memWrite;
    logic pdActive;
    logic pdEnd;
    logic wdFire;
    logic alarmFire;

    // two-stage synchronisers for the link pins and supply sense
    always_ff @(posedge clk) begin
        sckSync <= {sckSync[0], link.sck};
        ceSync <= {ceSync[0], link.ce};
        mosiSync <= {mosiSync[0], link.mosi};
        supplySync <= {supplySync[0], systemSupplySense};
        sckPrev <= sckSync[1];
        cePrev <= ceSync[1];
        supplyPrev <= supplySync[1];
    end

    assign ceNow = ceSync[1];
    assign sckNow = sckSync[1];
    assign ceRise = ceNow & ~cePrev;
    assign sckEdge = sckNow ^ sckPrev;
    assign pdActive = intCtl_reg[rtc_spi_pkg::IC_POWER_DOWN];
    assign portOff = ~ceNow | pdActive;
    // input latched on return to idle, output moved on leaving it
    assign strobe = sckEdge & (sckNow == idleLevel_reg) & ~portOff;
    assign shiftEdge = sckEdge & (sckNow != idleLevel_reg) & ~portOff;
    assign byteDone = strobe & (bitCnt_reg == 3'h7);
    assign inByte = {shiftIn_reg[6:0], mosiSync[1]};
    assign cmdAddr = {inByte[rtc_spi_pkg::CMD_CLOCK_BIT], inByte[4:0]};
    // upper bit held so clock accesses wrap to 20h, RAM to 00h
    assign nextAddr = {addr_reg[5], addr_reg[4:0] + 5'h01};
    assign rdAddr = gotCmd_reg ? nextAddr : cmdAddr;
    assign loadOut = byteDone & (gotCmd_reg ? ~isWrite_reg
        : ~inByte[rtc_spi_pkg::CMD_WRITE_BIT]);
    assign statusRead = loadOut & (rdAddr == rtc_spi_pkg::STATUS_ADDR);
    assign memWrite = byteDone & gotCmd_reg & isWrite_reg;
    assign pdEnd = pdActive & supplySync[1] & ~supplyPrev;

    // selects clock register or RAM by the upper address bit
    always_comb begin
        if (rdAddr == rtc_spi_pkg::STATUS_ADDR) begin
            rdData = status_reg;
        end else if (rdAddr == rtc_spi_pkg::INTCTL_ADDR) begin
            rdData = intCtl_reg;
        end else if (rdAddr[5]) begin
            rdData = clkRegs[rdAddr[4:0]];
        end else begin
            rdData = ram[rdAddr[4:0]];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            idleLevel_reg <= 1'b0;
        end else if (ceRise) begin
            idleLevel_reg <= sckNow;
        end
    end

    // serial engine; cleared whenever enable is low
    always_ff @(posedge clk) begin
        if (rst || portOff) begin
            bitCnt_reg <= 3'h0;
            gotCmd_reg <= 1'b0;
            isWrite_reg <= 1'b0;
            addr_reg <= 6'h00;
            shiftIn_reg <= 8'h00;
            shiftOut_reg <= 8'h00;
            misoOe_reg <= 1'b0;
            misoOut_reg <= 1'b0;
        end else if (strobe) begin
            shiftIn_reg <= inByte;
            bitCnt_reg <= bitCnt_reg + 3'h1;
            if (byteDone && !gotCmd_reg) begin
                gotCmd_reg <= 1'b1;
                isWrite_reg <= inByte[rtc_spi_pkg::CMD_WRITE_BIT];
                addr_reg <= cmdAddr;
            end else if (byteDone) begin
                addr_reg <= nextAddr;
            end
            if (loadOut) begin
                shiftOut_reg <= rdData;
                misoOe_reg <= 1'b1;
            end
        end else if (shiftEdge && misoOe_reg) begin
            misoOut_reg <= shiftOut_reg[7];
            shiftOut_reg <= {shiftOut_reg[6:0], 1'b0};
        end
    end

    always_ff @(posedge clk) begin
        if (memWrite) begin
            if (addr_reg[5]) begin
                clkRegs[addr_reg[4:0]] <= inByte;
            end else begin
                ram[addr_reg[4:0]] <= inByte;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            intCtl_reg <= 8'h00;
        end else if (memWrite && addr_reg == rtc_spi_pkg::INTCTL_ADDR) begin
            intCtl_reg <= inByte;
        end else if (pdEnd) begin
            intCtl_reg[rtc_spi_pkg::IC_POWER_DOWN] <= 1'b0;
        end
    end

    // read clears all but power sense; a new event in that cycle wins, except a delayed alarm, which the read cancels
    always_comb begin
        status_next = status_reg;
        if (statusRead) begin
            status_next = status_reg & rtc_spi_pkg::STATUS_KEEP_MASK;
        end
        if (wdFire) begin
            status_next[rtc_spi_pkg::ST_WATCHDOG] = 1'b1;
        end
        if (powerFailEvent && intCtl_reg[rtc_spi_pkg::IC_POWER_SENSE]) begin
            status_next[rtc_spi_pkg::ST_POWER_SENSE] = 1'b1;
            status_next[rtc_spi_pkg::ST_INT_TRUE] = 1'b1;
        end
        if (alarmFire) begin
            status_next[rtc_spi_pkg::ST_ALARM] = 1'b1;
            status_next[rtc_spi_pkg::ST_INT_TRUE] = 1'b1;
        end
        if (periodicEvent && intCtl_reg[3:0] != 4'h0) begin
            status_next[rtc_spi_pkg::ST_CLOCK] = 1'b1;
            status_next[rtc_spi_pkg::ST_INT_TRUE] = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            status_reg <= rtc_spi_pkg::STATUS_RESET;
        end else begin
            status_reg <= status_next;
        end
    end

    // any enable rise counts as the keep-alive toggle
    assign wdFire = intCtl_reg[rtc_spi_pkg::IC_WATCHDOG] & ~pdActive
        & (wdCnt_reg == 32'(WDOG_TIMEOUT - 1));
    always_ff @(posedge clk) begin
        if (rst || ceRise || wdFire || pdActive
                || !intCtl_reg[rtc_spi_pkg::IC_WATCHDOG]) begin
            wdCnt_reg <= 32'h0;
        end else begin
            wdCnt_reg <= wdCnt_reg + 32'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rstPulse_reg <= 8'h00;
        end else if (wdFire) begin
            rstPulse_reg <= rtc_spi_pkg::CPU_RESET_CYCLES;
        end else if (rstPulse_reg != 8'h00) begin
            rstPulse_reg <= rstPulse_reg - 8'h01;
        end
    end

    assign alarmFire = DELAYED_ALARM
        ? (alarmPending_reg & ~statusRead
            & (alarmCnt_reg == 32'(ALARM_DELAY - 1)))
        : (alarmEvent & intCtl_reg[rtc_spi_pkg::IC_ALARM]);
    always_ff @(posedge clk) begin
        if (rst || statusRead || alarmFire) begin
            alarmPending_reg <= 1'b0;
            alarmCnt_reg <= 32'h0;
        end else if (DELAYED_ALARM && alarmEvent
                && intCtl_reg[rtc_spi_pkg::IC_ALARM]) begin
            alarmPending_reg <= 1'b1;
            alarmCnt_reg <= 32'h0;
        end else if (alarmPending_reg) begin
            alarmCnt_reg <= alarmCnt_reg + 32'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            hostResetN_reg <= 1'b1;
            pse_reg <= 1'b1;
            clkOut_reg <= 1'b1;
        end else if (pdActive && !pdEnd) begin
            hostResetN_reg <= 1'b0;
            pse_reg <= 1'b0;
            clkOut_reg <= 1'b0;
        end else begin
            hostResetN_reg <= (rstPulse_reg == 8'h00) & ~wdFire;
            pse_reg <= 1'b1;
            clkOut_reg <= 1'b1;
        end
    end

    assign hostResetN = hostResetN_reg;
    assign powerSwitchEnable = pse_reg;
    assign clkOutEnable = clkOut_reg;
    assign irqActive = status_reg[rtc_spi_pkg::ST_INT_TRUE];
    assign link.misoOut = misoOut_reg;
    assign link.misoOe = misoOe_reg;
endmodule

// [hdl/rtc_spi_pkg.sv]
// constants shared by both ends of the clock-chip serial port
// assumes a 200 MHz system clock on each end and a bench link of 80 ns
// Function
// - Idle clock level sampled when enable rises
// - One clock per bit, eight bits per group
// - Command and data bytes travel MSB first
// - First byte after enable is the command
// - Command bit 7 high writes, low reads
// - Command bit 5 selects clock registers or RAM
// - Host always sends command bit 6 as zero
// - Every transfer starts with one command byte
// - Reads drive output line, writes take input
// - Single access moves one byte then drops enable
// - Address increments after every burst byte
// - Low address wraps: RAM to 00h, clock 20h
// - Watchdog resets host unless enable toggles
// - Host enables power sensing before power-down
// - Host reads status twice to confirm failure
// - Power-down holds reset, clock out, port off
// - Supply return ends power-down, reopens port
// - Restore re-enables clock out, switch, reset high
// - Delayed alarm cancelled by earlier status read
// - Enable low resets port, output driver off
// - Output driven only while read byte ready
package rtc_spi_pkg;
    localparam int CLK_PERIOD_NS = 5;
    localparam int SCK_PERIOD_NS = 80;
    localparam int HALF_CYCLES = SCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam int ALARM_DELAY_NS = 8300000;
    localparam int ALARM_DELAY_CYCLES = ALARM_DELAY_NS / CLK_PERIOD_NS;
    localparam int WDOG_TIMEOUT_NS = 1000000;
    localparam int WDOG_TIMEOUT_CYCLES = WDOG_TIMEOUT_NS / CLK_PERIOD_NS;
    localparam logic [7:0] CPU_RESET_CYCLES = 8'h40;

    // command byte fields
    localparam int CMD_WRITE_BIT = 7;
    localparam int CMD_TEST_BIT = 6;
    localparam int CMD_CLOCK_BIT = 5;

    // clock-side locations, bit 5 set
    localparam logic [5:0] STATUS_ADDR = 6'h30;
    localparam logic [5:0] INTCTL_ADDR = 6'h32;

    // interrupt control bits
    localparam int IC_WATCHDOG = 7;
    localparam int IC_POWER_DOWN = 6;
    localparam int IC_POWER_SENSE = 5;
    localparam int IC_ALARM = 4;

    // status bits
    localparam int ST_WATCHDOG = 6;
    localparam int ST_INT_TRUE = 3;
    localparam int ST_POWER_SENSE = 2;
    localparam int ST_ALARM = 1;
    localparam int ST_CLOCK = 0;
    localparam logic [7:0] STATUS_RESET = 8'h10;
    localparam logic [7:0] STATUS_KEEP_MASK = 8'h04;

    // host controller register port
    localparam logic [2:0] HREG_CTRL = 3'h0;
    localparam logic [2:0] HREG_TXDATA = 3'h1;
    localparam logic [2:0] HREG_RXDATA = 3'h2;
    localparam logic [2:0] HREG_STATUS = 3'h3;
    localparam logic [2:0] HREG_KICK = 3'h4;
    localparam int CTRL_LEN_LSB = 8;
    localparam int HST_BUSY = 0;
    localparam int HST_TXFULL = 1;
    localparam int HST_RXVALID = 2;
endpackage

// [hdl/rtc_spi_if.sv]
// serial link between the host controller and the clock chip port
// assumes the bench reads misoLine; an undriven line reads high
`timescale 1ns/10ps
interface rtc_spi_if;
    logic sck;
    logic ce;
    logic mosi;
    logic misoOut;
    logic misoOe;
    logic misoLine;

    assign misoLine = misoOe ? misoOut : 1'b1;

    modport dev (input sck, input ce, input mosi, output misoOut,
        output misoOe);
    modport host (output sck, output ce, output mosi, input misoLine);
endinterface

// [hdl/rtc_spi_host.sv]
// host controller: drives enable, serial clock and data from a small
// register port; one byte of transmit and receive holding each
// assumes the device latches on return to idle (shift on leave)
`timescale 1ns/10ps
module rtc_spi_host #(
    parameter bit CPOL = 1'b0,
    parameter int HALF = rtc_spi_pkg::HALF_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    rtc_spi_if.host link,
    input wire logic [2:0] busAddr,
    input wire logic [15:0] busWrData,
    input wire logic busWr,
    input wire logic busRd,
    output logic [15:0] busRdData
);
    typedef enum logic [2:0] {
        IDLE, SETUP, LEAD, TRAIL, WAITTX, HOLD, GAP
    } hstate_t;

    hstate_t state_reg;
    logic [7:0] cnt_reg;
    logic [1:0] misoSync;
    logic [7:0] shift_reg;
    logic [7:0] sin_reg;
    logic [2:0] bitIdx_reg;
    logic [5:0] remain_reg;
    logic isCmd_reg;
    logic isWrite_reg;
    logic sck_reg;
    logic ce_reg;
    logic mosi_reg;
    logic [7:0] txData_reg;
    logic txFull_reg;
    logic [7:0] rxData_reg;
    logic rxValid_reg;
    logic [15:0] busRdData_reg;

    logic halfDone;
    logic startCmd;
    logic startKick;
    logic byteEnd;
    logic lastByte;
    logic txTake;
    logic rxPut;

    assign halfDone = cnt_reg == 8'(HALF - 1);
    assign startCmd = busWr & (busAddr == rtc_spi_pkg::HREG_CTRL)
        & (state_reg == IDLE);
    assign startKick = busWr & (busAddr == rtc_spi_pkg::HREG_KICK)
        & (state_reg == IDLE);
    assign byteEnd = (state_reg == TRAIL) & halfDone & (bitIdx_reg == 3'h7);
    assign lastByte = ~isCmd_reg & (remain_reg == 6'h01);
    assign txTake = ((byteEnd & ~lastByte) | (state_reg == WAITTX))
        & isWrite_reg & txFull_reg;
    assign rxPut = byteEnd & ~isCmd_reg & ~isWrite_reg;

    always_ff @(posedge clk) begin
        misoSync <= {misoSync[0], link.misoLine};
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= IDLE;
            cnt_reg <= 8'h00;
        end else begin
            cnt_reg <= (halfDone || state_reg == IDLE
                || state_reg == WAITTX) ? 8'h00 : cnt_reg + 8'h01;
            case (state_reg)
                IDLE: begin
                    if (startCmd) begin
                        state_reg <= SETUP;
                    end else if (startKick) begin
                        state_reg <= HOLD;
                    end
                end
                SETUP: begin
                    if (halfDone) begin
                        state_reg <= LEAD;
                    end
                end
                LEAD: begin
                    if (halfDone) begin
                        state_reg <= TRAIL;
                    end
                end
                TRAIL: begin
                    if (halfDone && bitIdx_reg != 3'h7) begin
                        state_reg <= LEAD;
                    end else if (byteEnd && lastByte) begin
                        state_reg <= HOLD;
                    end else if (byteEnd && isWrite_reg && !txFull_reg) begin
                        state_reg <= WAITTX;
                    end else if (byteEnd) begin
                        state_reg <= LEAD;
                    end
                end
                WAITTX: begin
                    if (txFull_reg) begin
                        state_reg <= LEAD;
                    end
                end
                HOLD: begin
                    if (halfDone) begin
                        state_reg <= GAP;
                    end
                end
                GAP: begin
                    if (halfDone) begin
                        state_reg <= IDLE;
                    end
                end
                default: begin
                    state_reg <= IDLE;
                end
            endcase
        end
    end

    // pins and shifting; sck rests at CPOL so the device reads it at ce rise
    always_ff @(posedge clk) begin
        if (rst) begin
            sck_reg <= CPOL;
            ce_reg <= 1'b0;
            mosi_reg <= 1'b0;
            shift_reg <= 8'h00;
            sin_reg <= 8'h00;
            bitIdx_reg <= 3'h0;
            remain_reg <= 6'h00;
            isCmd_reg <= 1'b0;
            isWrite_reg <= 1'b0;
        end else begin
            if (startCmd) begin
                ce_reg <= 1'b1;
                isCmd_reg <= 1'b1;
                isWrite_reg <= busWrData[rtc_spi_pkg::CMD_WRITE_BIT];
                // bit 6 always sent as zero; test mode is not used
                shift_reg <= {busWrData[rtc_spi_pkg::CMD_WRITE_BIT], 1'b0,
                    busWrData[5:0]};
                remain_reg <= (busWrData[13:8] == 6'h00) ? 6'h01
                    : busWrData[13:8];
                bitIdx_reg <= 3'h0;
            end else if (startKick) begin
                ce_reg <= 1'b1;
            end
            if (state_reg == LEAD && cnt_reg == 8'h00) begin
                sck_reg <= ~CPOL;
                mosi_reg <= shift_reg[7];
                shift_reg <= {shift_reg[6:0], 1'b0};
            end
            if (state_reg == TRAIL && cnt_reg == 8'h00) begin
                sck_reg <= CPOL;
                sin_reg <= {sin_reg[6:0], misoSync[1]};
            end
            if (state_reg == TRAIL && halfDone) begin
                bitIdx_reg <= bitIdx_reg + 3'h1;
            end
            if (byteEnd) begin
                isCmd_reg <= 1'b0;
                if (!isCmd_reg) begin
                    remain_reg <= remain_reg - 6'h01;
                end
                if (!isWrite_reg) begin
                    shift_reg <= 8'h00;
                end
            end
            if (txTake) begin
                shift_reg <= txData_reg;
            end
            if (state_reg == HOLD && halfDone) begin
                ce_reg <= 1'b0;
            end
        end
    end

    // a refill in the cycle the byte is taken keeps the flag set
    always_ff @(posedge clk) begin
        if (rst) begin
            txData_reg <= 8'h00;
            txFull_reg <= 1'b0;
        end else if (busWr && busAddr == rtc_spi_pkg::HREG_TXDATA) begin
            txData_reg <= busWrData[7:0];
            txFull_reg <= 1'b1;
        end else if (txTake) begin
            txFull_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rxData_reg <= 8'h00;
            rxValid_reg <= 1'b0;
        end else if (rxPut) begin
            rxData_reg <= sin_reg;
            rxValid_reg <= 1'b1;
        end else if (busRd && busAddr == rtc_spi_pkg::HREG_RXDATA) begin
            rxValid_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            busRdData_reg <= 16'h0000;
        end else if (busRd) begin
            case (busAddr)
                rtc_spi_pkg::HREG_RXDATA: busRdData_reg <= {8'h00, rxData_reg};
                rtc_spi_pkg::HREG_STATUS: begin
                    busRdData_reg <= {13'h0000, rxValid_reg, txFull_reg,
                        state_reg != IDLE};
                end
                default: busRdData_reg <= 16'h0000;
            endcase
        end else begin
            busRdData_reg <= 16'h0000;
        end
    end

    assign busRdData = busRdData_reg;
    assign link.sck = sck_reg;
    assign link.ce = ce_reg;
    assign link.mosi = mosi_reg;
endmodule

// [test/rtc_spi_props.sv]
// assertions on the serial link between host controller and clock chip
// assumes host clock polarity 0 and half periods of eight clocks
`timescale 1ns/10ps
module rtc_spi_props (
    input wire logic clk,
    input wire logic rst,
    input wire logic sck,
    input wire logic ce,
    input wire logic mosi,
    input wire logic misoOut,
    input wire logic misoOe,
    input wire logic misoLine
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic sckDly;
    logic [3:0] bitCnt;
    logic isWrite;
    // strobes counted on the raw pins, saturating well past one byte
    always_ff @(posedge clk) sckDly <= sck;
    always_ff @(posedge clk) begin
        if (rst || !ce)
            bitCnt <= 4'h0;
        else if (sckDly && !sck && bitCnt != 4'hf)
            bitCnt <= bitCnt + 4'h1;
    end
    always_ff @(posedge clk) begin
        if (sckDly && !sck && bitCnt == 4'h0)
            isWrite <= mosi;
    end
    sequence frameStart;
        !ce ##1 ce;
    endsequence
    sequence halfHigh;
        sck [*8] ##1 !sck;
    endsequence
    AST_CE_LEAD: assert property (frameStart |-> !sck [*7])
        else $error("serial clock left idle too soon");
    AST_HALF: assert property ($rose(sck) |-> halfHigh)
        else $error("serial clock half period wrong");
    AST_IDLE: assert property (!ce |-> !sck)
        else $error("serial clock not idle outside frame");
    AST_MOSI: assert property (sck && sckDly |-> $stable(mosi))
        else $error("data in moved before strobe");
    AST_MISO: assert property ($fell(sck) && misoOe
        |-> misoLine == $past(misoLine, 3))
        else $error("data out moved near strobe");
    AST_OE_OFF: assert property (!ce [*6] |-> !misoOe)
        else $error("output driven with enable low");
    AST_OE_RISE: assert property ($rose(misoOe)
        |-> ce && bitCnt >= 4'h8)
        else $error("output driven before command done");
    AST_OE_WRITE: assert property (ce && isWrite
        && bitCnt != 4'h0 |-> !misoOe)
        else $error("output driven during write");
endmodule

// [test/tb.sv]
// bench: host controller and clock-chip port joined by the link
// assumes shortened device counts; bus strobes one cycle each
`timescale 1ns/10ps
`define CHK(a, b) begin \
    samplesChecked++; \
    if ((a) !== (b)) begin \
        badCount++; \
        $display("BAD %0t got %h want %h", $time, (a), (b)); \
    end \
end
module tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] busAddr = 3'h0;
    logic [15:0] busWrData = 16'h0000;
    logic busWr = 1'b0;
    logic busRd = 1'b0;
    logic [15:0] busRdData;
    logic supply = 1'b0;
    logic alarm = 1'b0;
    logic pfail = 1'b0;
    logic hostResetN, power_switch_enable_output, clkOut, irq;
    logic resetSeen = 1'b0;
    int badCount = 0;
    int samplesChecked = 0;
    rtc_spi_if link ();
    rtc_spi_host u_rtc_spi_host (.clk(clk), .rst(rst), .link(link.host),
        .busAddr(busAddr), .busWrData(busWrData), .busWr(busWr),
        .busRd(busRd), .busRdData(busRdData));
    rtc_spi_device #(.ALARM_DELAY(50), .WDOG_TIMEOUT(300)) u_rtc_spi_device (
        .clk(clk), .rst(rst), .link(link.dev), .systemSupplySense(supply),
        .powerFailEvent(pfail), .alarmEvent(alarm), .periodicEvent(1'b0),
        .hostResetN(hostResetN), .powerSwitchEnable(power_switch_enable_output),
        .clkOutEnable(clkOut), .irqActive(irq));
    rtc_spi_props u_rtc_spi_props (.clk(clk), .rst(rst), .sck(link.sck),
        .ce(link.ce), .mosi(link.mosi), .misoOut(link.misoOut),
        .misoOe(link.misoOe), .misoLine(link.misoLine));
    always #2.5 clk = ~clk;
    // reset pulses are short, so they are latched for the watchdog check
    always @(posedge clk) if (hostResetN === 1'b0) resetSeen <= 1'b1;
    task automatic endOfTest();
        if (badCount == 0 && samplesChecked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic busWrite(input logic [2:0] a, input logic [15:0] d);
        busAddr <= a;
        busWrData <= d;
        busWr <= 1'b1;
        @(posedge clk);
        busWr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic busRead(input logic [2:0] a, output logic [15:0] d);
        busAddr <= a;
        busRd <= 1'b1;
        @(posedge clk);
        busRd <= 1'b0;
        #1 d = busRdData;
        @(posedge clk);
    endtask
    task automatic waitHost(input int b, input logic v);
        logic [15:0] s;
        for (int i = 0; i < 3000; i++) begin
            busRead(rtc_spi_pkg::HREG_STATUS, s);
            if (s[b] === v) return;
        end
        badCount++;
        $display("BAD %0t host wait timed out", $time);
        endOfTest();
    endtask
    // one frame of n bytes; read bytes are compared with d0 and d1
    task automatic frame(input logic [7:0] cmd, input int n,
        input logic [7:0] d0, input logic [7:0] d1);
        logic [15:0] s;
        if (cmd[7]) busWrite(rtc_spi_pkg::HREG_TXDATA, {8'h00, d0});
        // the count field holds the number of data bytes itself
        busWrite(rtc_spi_pkg::HREG_CTRL, {2'b00, 6'(n), cmd});
        for (int i = 0; i < n; i++) begin
            if (cmd[7] && i > 0) begin
                waitHost(rtc_spi_pkg::HST_TXFULL, 1'b0);
                busWrite(rtc_spi_pkg::HREG_TXDATA, {8'h00, d1});
            end else if (!cmd[7]) begin
                waitHost(rtc_spi_pkg::HST_RXVALID, 1'b1);
                busRead(rtc_spi_pkg::HREG_RXDATA, s);
                `CHK(s[7:0], i == 0 ? d0 : d1)
            end
        end
        waitHost(rtc_spi_pkg::HST_BUSY, 1'b0);
    endtask
    task automatic testWrap();
        frame(8'h9f, 1, 8'ha5, 8'h00);
        frame(8'h80, 1, 8'h3c, 8'h00);
        frame(8'h1f, 2, 8'ha5, 8'h3c);
        frame(8'hbf, 2, 8'h11, 8'h22);
        frame(8'h60, 1, 8'h22, 8'h00);
        frame(8'h3f, 1, 8'h11, 8'h00);
    endtask
    task automatic testPowerDown();
        frame(8'hb2, 1, 8'h20, 8'h00);
        pfail <= 1'b1;
        @(posedge clk);
        pfail <= 1'b0;
        @(posedge clk);
        `CHK(irq, 1'b1)
        // first-time bit still set; the second read keeps power sense only
        frame(8'h30, 1, 8'h1c, 8'h00);
        frame(8'h30, 1, 8'h04, 8'h00);
        frame(8'hb2, 1, 8'h40, 8'h00);
        `CHK({hostResetN, power_switch_enable_output, clkOut}, 3'b000)
        frame(8'h1f, 1, 8'hff, 8'h00);
        supply <= 1'b1;
        repeat (8) @(posedge clk);
        `CHK({hostResetN, power_switch_enable_output, clkOut}, 3'b111)
        frame(8'h1f, 1, 8'ha5, 8'h00);
    endtask
    task automatic testAlarm();
        frame(8'hb2, 1, 8'h10, 8'h00);
        alarm <= 1'b1;
        @(posedge clk);
        alarm <= 1'b0;
        repeat (30) @(posedge clk);
        `CHK(irq, 1'b0)
        repeat (40) @(posedge clk);
        `CHK(irq, 1'b1)
        frame(8'h30, 1, 8'h0e, 8'h00);
        `CHK(irq, 1'b0)
        // alarm raised mid-command; the status read lands inside the delay
        fork
            frame(8'h30, 1, 8'h04, 8'h00);
            begin
                repeat (100) @(posedge clk);
                alarm <= 1'b1;
                @(posedge clk);
                alarm <= 1'b0;
            end
        join
        `CHK(irq, 1'b0)
    endtask
    task automatic testWatchdog();
        frame(8'hb2, 1, 8'h80, 8'h00);
        resetSeen = 1'b0;
        repeat (4) begin
            busWrite(rtc_spi_pkg::HREG_KICK, 16'h0000);
            repeat (100) @(posedge clk);
        end
        `CHK(resetSeen, 1'b0)
        repeat (400) @(posedge clk);
        `CHK(resetSeen, 1'b1)
        frame(8'hb2, 1, 8'h00, 8'h00);
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        testWrap();
        testPowerDown();
        testAlarm();
        testWatchdog();
        endOfTest();
    end
endmodule
